// ==== src/rgm_cfg.svh ====
// Purpose: Constants for the region attribute matcher
// Assumes: 32-bit descriptors, 12-bit control register selectors
// Notes: Widths, field positions, selector codes and reset values only
`ifndef RGM_CFG_SVH
`define RGM_CFG_SVH

// ----------------------------------------------------------------
// Control register selectors
// ----------------------------------------------------------------
`define RGM_SEL_W 12
`define RGM_SEL_DESC0 12'h004
`define RGM_SEL_DESC1 12'h005

// ----------------------------------------------------------------
// Descriptor fields
// ----------------------------------------------------------------
`define RGM_DESC_W 32
`define RGM_BASE_HI 31
`define RGM_BASE_LO 24
`define RGM_MASK_HI 23
`define RGM_MASK_LO 16
`define RGM_EN_BIT 15
`define RGM_QUAL_HI 14
`define RGM_QUAL_LO 13
`define RGM_CM_BIT 6
`define RGM_BWE_BIT 5
`define RGM_WP_BIT 2
`define RGM_ADDR_HI 31
`define RGM_ADDR_LO 24

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define RGM_DESC_RST 32'h0000_0000
`define RGM_DATA_ZERO 32'h0000_0000

`endif

// ==== src/rgm_pkg.sv ====
// Purpose: Types and shared decode for the region attribute matcher
// Assumes: rgm_cfg.svh field positions
// Notes: Attribute set is shared by descriptors and defaults
`include "rgm_cfg.svh"

package rgm_pkg;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef struct packed {
        logic noncache;
        logic bufwr;
        logic wprot;
    } rgm_attr_t;

    typedef enum logic [1:0] {
        RGM_IDLE = 2'b01,
        RGM_WAIT = 2'b10
    } rgm_state_t;

    // ------------------------------------------------------------
    // Functions
    // ------------------------------------------------------------
    function automatic rgm_attr_t rgm_attr_of(
        input logic [`RGM_DESC_W-1:0] desc);
        rgm_attr_t a;
        a.noncache = desc[`RGM_CM_BIT];
        a.bufwr = desc[`RGM_BWE_BIT];
        a.wprot = desc[`RGM_WP_BIT];
        return a;
    endfunction

    function automatic logic rgm_priv_ok(input logic [1:0] qual,
                                         input logic supervisor);
        return qual[1] | (qual[0] == supervisor);
    endfunction

endpackage

// ==== src/rgm_term_if.sv ====
// Purpose: Carrier between attribute logic and write sequencer
// Assumes: Single clock domain
// Notes: ctl side starts a reference, seq side terminates it
`timescale 1ns/1ps

interface rgm_term_if;
    logic start;
    logic is_write;
    logic bypass;
    rgm_pkg::rgm_attr_t attr;
    logic ready;
    logic term_ok;
    logic term_err;
    logic sys_wr_req;
    logic sys_wr_buffered;
    logic sys_done;
    logic sys_err;
    logic acc_err;

    modport ctl (
        output start, is_write, bypass, attr, sys_done, sys_err,
        input ready, term_ok, term_err, sys_wr_req, sys_wr_buffered,
        acc_err
    );
    modport seq (
        input start, is_write, bypass, attr, sys_done, sys_err,
        output ready, term_ok, term_err, sys_wr_req, sys_wr_buffered,
        acc_err
    );
endinterface

// ==== src/rgm_desc_match.sv ====
// Purpose: Match one descriptor against a reference
// Assumes: Descriptor held in flip-flops by the caller
// Notes: Purely combinational, reserved bits never looked at
`timescale 1ns/1ps
`include "rgm_cfg.svh"

module rgm_desc_match (
    // Descriptor
    input wire logic [`RGM_DESC_W-1:0] desc,
    // Reference
    input wire logic [7:0] addr_hi,
    input wire logic supervisor,
    // Result
    output logic hit
);
    import rgm_pkg::*;

    logic [7:0] diff;

    assign diff = (addr_hi ^ desc[`RGM_BASE_HI:`RGM_BASE_LO]) &
                  ~desc[`RGM_MASK_HI:`RGM_MASK_LO];
    assign hit = desc[`RGM_EN_BIT] & (diff == 8'h00) &
                 rgm_priv_ok(desc[`RGM_QUAL_HI:`RGM_QUAL_LO],
                             supervisor);
endmodule

// ==== src/rgm_wr_term.sv ====
// Purpose: Terminate references on the local bus
// Assumes: Bus controller answers with sys_done in the core clock
// Notes: Only unbuffered writes stall the local bus
`timescale 1ns/1ps

module rgm_wr_term (
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // Reference and termination
    rgm_term_if.seq tif
);
    import rgm_pkg::*;

    rgm_state_t state_ff;
    rgm_state_t nxt_state;
    logic to_sys;
    logic stall;

    assign to_sys = tif.start & tif.is_write & ~tif.bypass &
                    ~tif.attr.wprot;
    assign stall = to_sys & ~tif.attr.bufwr;
    assign tif.ready = (state_ff == RGM_IDLE);

    always_comb begin
        nxt_state = state_ff;
        unique case (state_ff)
            RGM_IDLE: begin
                if (stall) begin
                    nxt_state = RGM_WAIT;
                end
            end
            RGM_WAIT: begin
                if (tif.sys_done) begin
                    nxt_state = RGM_IDLE;
                end
            end
            default: nxt_state = RGM_IDLE;
        endcase
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            state_ff <= RGM_IDLE;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // ------------------------------------------------------------
    // Termination pulses
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!resetn) begin
            tif.term_ok <= 1'b0;
            tif.term_err <= 1'b0;
        end else begin
            tif.term_err <= tif.start & tif.is_write & ~tif.bypass &
                            tif.attr.wprot;
            tif.term_ok <= (tif.start & ~stall &
                            ~(tif.is_write & ~tif.bypass &
                              tif.attr.wprot)) |
                           (state_ff == RGM_WAIT & tif.sys_done);
        end
    end

    // Write errors never stall the local bus, so they come back late
    always_ff @(posedge clk) begin
        if (!resetn) begin
            tif.sys_wr_req <= 1'b0;
            tif.sys_wr_buffered <= 1'b0;
            tif.acc_err <= 1'b0;
        end else begin
            tif.sys_wr_req <= to_sys;
            tif.sys_wr_buffered <= to_sys & tif.attr.bufwr;
            tif.acc_err <= tif.sys_done & tif.sys_err;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    wprot_write_err_a: assert property (
        @(posedge clk) disable iff (!resetn)
        tif.start && tif.is_write && !tif.bypass && tif.attr.wprot
        |=> tif.term_err && !tif.term_ok && !tif.sys_wr_req)
        else $error("protected write not refused");
    wprot_read_ok_a: assert property (
        @(posedge clk) disable iff (!resetn)
        tif.start && !tif.is_write |=> tif.term_ok && !tif.term_err)
        else $error("read not terminated");
    buffered_fast_a: assert property (
        @(posedge clk) disable iff (!resetn)
        to_sys && tif.attr.bufwr
        |=> tif.term_ok && tif.sys_wr_buffered && tif.ready)
        else $error("buffered write not ended at once");
    unbuf_hold_a: assert property (
        @(posedge clk) disable iff (!resetn)
        stall |=> (!tif.term_ok && !tif.ready) until tif.sys_done)
        else $error("unbuffered write ended early");
    unbuf_end_a: assert property (
        @(posedge clk) disable iff (!resetn)
        state_ff == RGM_WAIT && tif.sys_done |=> tif.term_ok)
        else $error("unbuffered write not ended after bus");
    late_err_a: assert property (
        @(posedge clk) disable iff (!resetn)
        tif.sys_done && tif.sys_err |=> tif.acc_err)
        else $error("write error not reported");
    unbuf_wait_c: cover property (
        @(posedge clk) disable iff (!resetn)
        stall ##[1:20] tif.term_ok);
    buffered_c: cover property (
        @(posedge clk) disable iff (!resetn)
        to_sys && tif.attr.bufwr);
endmodule

// ==== src/rgm_top.sv ====
// Purpose: Assign effective attributes to core memory references
// Assumes: All inputs come from core logic on clk
// Notes: Descriptors reached by control register selector only
// Overview of operation
// - Two independent descriptors each give attributes for own region.
// - Flash and SRAM references bypass descriptor evaluation.
// - No enabled descriptor hit means cache control register defaults.
// - Descriptors are 32-bit, write-only, written only with supervisor rights.
// - Selector codes 0x004 and 0x005 reach descriptor 0 and 1.
// - Background debug mode may read both descriptors back.
// - Reset clears enable bit 15; disabled descriptor never matches.
// - Base field bits 31-24 compared with address bits 31-24.
// - Set mask bit drops that base bit from the compare.
// - Matching descriptor supplies cacheability, buffering and protection.
// - Qualifier 00 user only, 01 supervisor only, 1x any mode.
// - Bit 6 clear means cacheable, set means non-cacheable.
// - Buffered bit clear holds write termination until system bus done.
// - Buffered bit set ends write at once; bus controller finishes it.
// - Write-protect set refuses writes with access error; reads pass.
// - Write access errors are reported imprecisely, later than the write.
`timescale 1ns/1ps
`include "rgm_cfg.svh"

module rgm_top (
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // Control register port
    input wire logic ctl_wr_valid,
    input wire logic ctl_rd_valid,
    input wire logic [`RGM_SEL_W-1:0] ctl_sel,
    input wire logic [`RGM_DESC_W-1:0] ctl_wr_data,
    input wire logic ctl_supervisor,
    input wire logic debug_mode,
    output logic ctl_ack,
    output logic ctl_err,
    output logic [`RGM_DESC_W-1:0] ctl_rd_data,
    // Defaults from the cache control register
    input wire rgm_pkg::rgm_attr_t dflt_attr,
    // Reference from the core local bus
    input wire logic ref_valid,
    output logic ref_ready,
    input wire logic [31:0] ref_addr,
    input wire logic ref_supervisor,
    input wire logic ref_write,
    input wire logic ref_in_flash,
    input wire logic ref_in_sram,
    // Effective attributes
    output logic attr_valid,
    output rgm_pkg::rgm_attr_t attr_out,
    output logic attr_bypass,
    output logic [1:0] attr_region_hit,
    // Local bus termination
    output logic term_ok,
    output logic term_err,
    // Bus controller
    output logic sys_wr_req,
    output logic sys_wr_buffered,
    input wire logic sys_wr_done,
    input wire logic sys_wr_err,
    output logic acc_err_imprecise
);
    import rgm_pkg::*;

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    logic [`RGM_DESC_W-1:0] desc0_ff;
    logic [`RGM_DESC_W-1:0] desc1_ff;
    logic sel0;
    logic sel1;
    logic sel_hit;
    logic wr_allowed;
    logic rd_allowed;
    logic ctl_ack_ff;
    logic ctl_err_ff;
    logic [`RGM_DESC_W-1:0] ctl_rd_data_ff;
    logic [`RGM_DESC_W-1:0] nxt_rd_data;
    logic hit0;
    logic hit1;
    logic bypass;
    logic take;
    rgm_attr_t nxt_attr;
    rgm_attr_t attr_ff;
    logic attr_valid_ff;
    logic attr_bypass_ff;
    logic [1:0] attr_region_hit_ff;

    rgm_term_if tif ();

    // ------------------------------------------------------------
    // Control register decode
    // ------------------------------------------------------------
    assign sel0 = (ctl_sel == `RGM_SEL_DESC0);
    assign sel1 = (ctl_sel == `RGM_SEL_DESC1);
    assign sel_hit = sel0 | sel1;
    // Debug mode acts with supervisor rights on the control space
    assign wr_allowed = ctl_supervisor | debug_mode;
    // Ordinary code may never read a descriptor back
    assign rd_allowed = debug_mode;

    // ------------------------------------------------------------
    // Descriptor storage
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!resetn) begin
            desc0_ff <= `RGM_DESC_RST;
        end else if (ctl_wr_valid && sel0 && wr_allowed) begin
            desc0_ff <= ctl_wr_data;
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            desc1_ff <= `RGM_DESC_RST;
        end else if (ctl_wr_valid && sel1 && wr_allowed) begin
            desc1_ff <= ctl_wr_data;
        end
    end

    // ------------------------------------------------------------
    // Control port answer
    // ------------------------------------------------------------
    // Other selectors belong to other control registers: no answer
    always_comb begin
        nxt_rd_data = `RGM_DATA_ZERO;
        if (ctl_rd_valid && !ctl_wr_valid && rd_allowed) begin
            if (sel0) begin
                nxt_rd_data = desc0_ff;
            end else if (sel1) begin
                nxt_rd_data = desc1_ff;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            ctl_ack_ff <= 1'b0;
            ctl_err_ff <= 1'b0;
            ctl_rd_data_ff <= `RGM_DATA_ZERO;
        end else begin
            ctl_ack_ff <= (ctl_wr_valid | ctl_rd_valid) & sel_hit;
            ctl_err_ff <= sel_hit &
                          ((ctl_wr_valid & ~wr_allowed) |
                           (~ctl_wr_valid & ctl_rd_valid &
                            ~rd_allowed));
            ctl_rd_data_ff <= nxt_rd_data;
        end
    end

    assign ctl_ack = ctl_ack_ff;
    assign ctl_err = ctl_err_ff;
    assign ctl_rd_data = ctl_rd_data_ff;

    // ------------------------------------------------------------
    // Region matching
    // ------------------------------------------------------------
    rgm_desc_match u_match0 (
        .desc(desc0_ff),
        .addr_hi(ref_addr[`RGM_ADDR_HI:`RGM_ADDR_LO]),
        .supervisor(ref_supervisor),
        .hit(hit0)
    );

    rgm_desc_match u_match1 (
        .desc(desc1_ff),
        .addr_hi(ref_addr[`RGM_ADDR_HI:`RGM_ADDR_LO]),
        .supervisor(ref_supervisor),
        .hit(hit1)
    );

    // On-chip memories answer for themselves
    assign bypass = ref_in_flash | ref_in_sram;
    assign take = ref_valid & tif.ready;
    assign ref_ready = tif.ready;

    // Fixed priority keeps the answer defined for overlapping regions
    always_comb begin
        nxt_attr = dflt_attr;
        if (bypass) begin
            nxt_attr = '0;
        end else if (hit0) begin
            nxt_attr = rgm_attr_of(desc0_ff);
        end else if (hit1) begin
            nxt_attr = rgm_attr_of(desc1_ff);
        end
    end

    // ------------------------------------------------------------
    // Attribute outputs
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!resetn) begin
            attr_valid_ff <= 1'b0;
        end else begin
            attr_valid_ff <= take;
        end
    end

    // Attributes stand until the next reference is taken
    always_ff @(posedge clk) begin
        if (!resetn) begin
            attr_ff <= '0;
            attr_bypass_ff <= 1'b0;
            attr_region_hit_ff <= 2'b00;
        end else if (take) begin
            attr_ff <= nxt_attr;
            attr_bypass_ff <= bypass;
            attr_region_hit_ff <= bypass ? 2'b00 : {hit1, hit0};
        end
    end

    assign attr_valid = attr_valid_ff;
    assign attr_out = attr_ff;
    assign attr_bypass = attr_bypass_ff;
    assign attr_region_hit = attr_region_hit_ff;

    // ------------------------------------------------------------
    // Termination
    // ------------------------------------------------------------
    assign tif.start = take;
    assign tif.is_write = ref_write;
    assign tif.bypass = bypass;
    assign tif.attr = nxt_attr;
    assign tif.sys_done = sys_wr_done;
    assign tif.sys_err = sys_wr_err;

    rgm_wr_term u_term (
        .clk(clk),
        .resetn(resetn),
        .tif(tif.seq)
    );

    assign term_ok = tif.term_ok;
    assign term_err = tif.term_err;
    assign sys_wr_req = tif.sys_wr_req;
    assign sys_wr_buffered = tif.sys_wr_buffered;
    assign acc_err_imprecise = tif.acc_err;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    reset_disables_a: assert property (
        @(posedge clk)
        $rose(resetn) |-> !desc0_ff[`RGM_EN_BIT] &&
                          !desc1_ff[`RGM_EN_BIT])
        else $error("descriptor enabled after reset");
    disabled_nohit_a: assert property (
        @(posedge clk) disable iff (!resetn)
        (!hit0 || desc0_ff[`RGM_EN_BIT]) &&
        (!hit1 || desc1_ff[`RGM_EN_BIT]))
        else $error("disabled descriptor matched");
    base_mask_a: assert property (
        @(posedge clk) disable iff (!resetn)
        hit0 |-> ((ref_addr[31:24] ^ desc0_ff[31:24]) &
                  ~desc0_ff[23:16]) == 8'h00)
        else $error("match outside base and mask");
    privilege_a: assert property (
        @(posedge clk) disable iff (!resetn)
        hit1 && !desc1_ff[14] |-> desc1_ff[13] == ref_supervisor)
        else $error("privilege qualifier ignored");
    user_write_block_a: assert property (
        @(posedge clk) disable iff (!resetn)
        ctl_wr_valid && sel_hit && !ctl_supervisor && !debug_mode
        |=> $stable(desc0_ff) && $stable(desc1_ff) && ctl_err)
        else $error("user write reached a descriptor");
    sup_write_a: assert property (
        @(posedge clk) disable iff (!resetn)
        ctl_wr_valid && sel1 && ctl_supervisor
        |=> desc1_ff == $past(ctl_wr_data) && ctl_ack && !ctl_err)
        else $error("descriptor write lost");
    debug_read_a: assert property (
        @(posedge clk) disable iff (!resetn)
        ctl_rd_valid && !ctl_wr_valid && sel0 && debug_mode
        |=> ctl_rd_data == $past(desc0_ff) && ctl_ack && !ctl_err)
        else $error("debug read back wrong");
    user_read_a: assert property (
        @(posedge clk) disable iff (!resetn)
        ctl_rd_valid && !ctl_wr_valid && sel_hit && !debug_mode
        |=> ctl_err && ctl_rd_data == `RGM_DATA_ZERO)
        else $error("descriptor readable outside debug");
    default_attr_a: assert property (
        @(posedge clk) disable iff (!resetn)
        take && !bypass && !hit0 && !hit1
        |=> attr_valid && attr_out == $past(dflt_attr) &&
            attr_region_hit == 2'b00)
        else $error("defaults not applied");
    priority_a: assert property (
        @(posedge clk) disable iff (!resetn)
        take && !bypass && hit0
        |=> attr_out.noncache == $past(desc0_ff[6]) &&
            attr_out.bufwr == $past(desc0_ff[5]) &&
            attr_out.wprot == $past(desc0_ff[2]))
        else $error("descriptor 0 did not win");
    bypass_a: assert property (
        @(posedge clk) disable iff (!resetn)
        take && bypass
        |=> attr_bypass && attr_region_hit == 2'b00 && term_ok &&
            !sys_wr_req)
        else $error("on-chip memory reference evaluated");
    stall_hold_a: assert property (
        @(posedge clk) disable iff (!resetn)
        take && ref_write && !bypass && !nxt_attr.wprot &&
        !nxt_attr.bufwr |=> !ref_ready && !term_ok && sys_wr_req)
        else $error("unbuffered write not held");
    desc1_attr_a: assert property (
        @(posedge clk) disable iff (!resetn)
        take && !bypass && !hit0 && hit1
        |=> attr_out.noncache == $past(desc1_ff[6]) &&
            attr_out.bufwr == $past(desc1_ff[5]) &&
            attr_out.wprot == $past(desc1_ff[2]))
        else $error("descriptor 1 attributes lost");
    other_sel_a: assert property (
        @(posedge clk) disable iff (!resetn)
        (ctl_wr_valid || ctl_rd_valid) && !sel_hit |=> !ctl_ack && !ctl_err)
        else $error("foreign selector answered");
    desc0_write_a: assert property (
        @(posedge clk) disable iff (!resetn)
        ctl_wr_valid && sel0 && ctl_supervisor
        |=> desc0_ff == $past(ctl_wr_data) && ctl_ack && !ctl_err)
        else $error("descriptor 0 write lost");
    // Read data must not leak a descriptor when nobody asks
    rd_idle_zero_a: assert property (
        @(posedge clk) disable iff (!resetn)
        !ctl_rd_valid |=> ctl_rd_data == `RGM_DATA_ZERO)
        else $error("read data without a read");
    refused_ack_a: assert property (
        @(posedge clk) disable iff (!resetn)
        ctl_wr_valid && sel_hit && !ctl_supervisor && !debug_mode |=> ctl_ack)
        else $error("refused write not acknowledged");
    both_hit_c: cover property (
        @(posedge clk) disable iff (!resetn)
        take && hit0 && hit1);
    debug_read_c: cover property (
        @(posedge clk) disable iff (!resetn)
        ctl_rd_valid && sel1 && debug_mode);
    wp_error_c: cover property (
        @(posedge clk) disable iff (!resetn)
        term_err);
endmodule

// ==== tb/rgm_bus_model.sv ====
// Purpose: Bus controller stand-in answering system-bus writes
// Assumes: Same clock as the matcher, one write in flight
// Notes: Delay and error are set by the bench per scenario
`timescale 1ns/1ps

module rgm_bus_model (
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // Scenario control
    input wire logic [3:0] dly,
    input wire logic err_en,
    // Write handshake
    input wire logic wr_req,
    output logic done,
    output logic err
);
    logic [3:0] cnt_ff;

    // ------------------------------------------------------------
    // Completion timer
    // ------------------------------------------------------------
    // Done comes dly cycles after the request is seen
    always_ff @(posedge clk) begin
        done <= 1'b0;
        err <= 1'b0;
        if (!resetn) begin
            cnt_ff <= 4'h0;
        end else if (wr_req) begin
            cnt_ff <= dly;
        end else if (cnt_ff == 4'h1) begin
            done <= 1'b1;
            err <= err_en;
            cnt_ff <= 4'h0;
        end else if (cnt_ff != 4'h0) begin
            cnt_ff <= cnt_ff - 4'h1;
        end
    end
endmodule

// ==== tb/testbench.sv ====
// Purpose: Self-checking bench for the region attribute matcher
// Assumes: Inputs change 1 ns after the rising clock edge
// Notes: Expected attributes are worked out from the field layout
`timescale 1ns/1ps
`include "rgm_cfg.svh"

module testbench;
    import rgm_pkg::*;
    logic clk = 0, resetn = 0, ctl_wr_valid = 0, ctl_rd_valid = 0;
    logic ctl_supervisor = 0, debug_mode = 0, ref_valid = 0;
    logic ref_supervisor = 0, ref_write = 0, ref_in_flash = 0;
    logic ref_in_sram = 0, err_en = 0;
    logic [11:0] ctl_sel = 0;
    logic [31:0] ctl_wr_data = 0, ref_addr = 0, ctl_rd_data;
    rgm_attr_t dflt_attr = 0, attr_out;
    logic ctl_ack, ctl_err, ref_ready, attr_valid, attr_bypass;
    logic term_ok, term_err, sys_wr_req, sys_wr_buffered;
    logic sys_wr_done, sys_wr_err, acc_err_imprecise;
    logic [1:0] attr_region_hit;
    logic [3:0] dly = 4'h1;
    int error_cnt = 0, compares = 0, acc_cnt = 0, n;

    // ------------------------------------------------------------
    // Clock, design, partner
    // ------------------------------------------------------------
    always #12.5 clk = ~clk;
    rgm_top dut (.clk, .resetn, .ctl_wr_valid, .ctl_rd_valid, .ctl_sel,
        .ctl_wr_data, .ctl_supervisor, .debug_mode, .ctl_ack, .ctl_err,
        .ctl_rd_data, .dflt_attr, .ref_valid, .ref_ready, .ref_addr,
        .ref_supervisor, .ref_write, .ref_in_flash, .ref_in_sram,
        .attr_valid, .attr_out, .attr_bypass, .attr_region_hit,
        .term_ok, .term_err, .sys_wr_req, .sys_wr_buffered,
        .sys_wr_done, .sys_wr_err, .acc_err_imprecise);
    rgm_bus_model bus (.clk, .resetn, .dly, .err_en, .wr_req(sys_wr_req),
        .done(sys_wr_done), .err(sys_wr_err));
    always @(posedge clk) if (acc_err_imprecise === 1'b1) acc_cnt++;

    task automatic chk(string nm, logic [31:0] e, logic [31:0] s);
        compares++;
        if (s !== e) begin
            error_cnt++;
            $display("MISMATCH %s expected %h seen %h", nm, e, s);
        end
    endtask

    task automatic test_done();
        if (error_cnt == 0 && compares > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    // Enabled descriptor; reserved bits always written as zero
    function automatic logic [31:0] d(logic [7:0] b, logic [7:0] m,
        logic [1:0] q, logic cm, logic bw, logic wp);
        return {b, m, 1'b1, q, 6'h0, cm, bw, 2'h0, wp, 2'h0};
    endfunction

    // One control access, answer judged one cycle later
    task automatic ctl(logic w, logic [11:0] sel, logic [31:0] dt,
        logic s, logic dbg, logic ack, logic er, logic [31:0] rd);
        ctl_wr_valid = w;
        ctl_rd_valid = !w;
        ctl_sel = sel;
        ctl_wr_data = dt;
        ctl_supervisor = s;
        debug_mode = dbg;
        @(posedge clk);
        #1;
        ctl_wr_valid = 0;
        ctl_rd_valid = 0;
        chk("ctl_ack", ack, ctl_ack);
        chk("ctl_err", er, ctl_err);
        chk("ctl_rd_data", rd, ctl_rd_data);
        @(posedge clk);
        #1;
    endtask

    // One reference; n counts cycles from take to termination
    task automatic rf(logic [31:0] a, logic s, logic w, logic [1:0] f,
        logic [1:0] eh, logic [2:0] ea, logic ee);
        while (ref_ready !== 1'b1) begin
            @(posedge clk);
            #1;
        end
        ref_addr = a;
        ref_supervisor = s;
        ref_write = w;
        {ref_in_sram, ref_in_flash} = f;
        ref_valid = 1;
        @(posedge clk);
        #1;
        ref_valid = 0;
        chk("attr_valid", 1, attr_valid);
        chk("attr_out", ea, attr_out);
        chk("attr_bypass", |f, attr_bypass);
        if (f == 0) chk("attr_region_hit", eh, attr_region_hit);
        chk("sys_wr_req", w & ~|f & ~ee, sys_wr_req);
        chk("sys_wr_buffered", w & ~|f & ~ee & ea[1],
            sys_wr_buffered);
        chk("ref_ready", !(w & ~|f & ~ee & ~ea[1]), ref_ready);
        n = 1;
        while (!(term_ok === 1'b1 || term_err === 1'b1) && n < 30) begin
            @(posedge clk);
            #1;
            n++;
        end
        chk("term_err", ee, term_err);
        chk("term_ok", !ee, term_ok);
        @(posedge clk);
        #1;
    endtask

    task automatic t_regs();
        dflt_attr = 3'h1;
        rf(32'h4500_0000, 1, 0, 0, 0, 3'h1, 0);
        ctl(0, 12'h004, 0, 1, 1, 1, 0, 0);
        ctl(1, 12'h004, 32'hFFFF_FFFF, 0, 0, 1, 1, 0);
        ctl(0, 12'h004, 0, 0, 1, 1, 0, 0);
        ctl(1, 12'h005, 32'hA5A5_5A5A, 1, 0, 1, 0, 0);
        ctl(0, 12'h005, 0, 0, 1, 1, 0, 32'hA5A5_5A5A);
        ctl(0, 12'h005, 0, 1, 0, 1, 1, 0);
        ctl(1, 12'h006, 0, 1, 0, 0, 0, 0);
    endtask

    task automatic t_match();
        dflt_attr = 3'h0;
        ctl(1, 12'h004, d(8'h40, 8'h0F, 2'h0, 1, 0, 0),
            1, 0, 1, 0, 0);
        ctl(1, 12'h005, d(8'h40, 8'h00, 2'h1, 0, 1, 0), 1, 0, 1, 0, 0);
        rf(32'h4000_0000, 0, 0, 0, 2'h1, 3'h4, 0);
        rf(32'h4000_0000, 1, 0, 0, 2'h2, 3'h2, 0);
        rf(32'h4F00_0000, 0, 0, 0, 2'h1, 3'h4, 0);
        rf(32'hC000_0000, 0, 0, 0, 2'h0, 3'h0, 0);
        ctl(1, 12'h004, d(8'h40, 8'h00, 2'h3, 0, 0, 1), 1, 0, 1, 0, 0);
        ctl(1, 12'h005, d(8'h40, 8'h00, 2'h2, 0, 1, 0), 1, 0, 1, 0, 0);
        rf(32'h4000_0000, 0, 1, 0, 2'h3, 3'h1, 1);
        rf(32'h4000_0000, 1, 0, 0, 2'h3, 3'h1, 0);
        rf(32'h4000_0000, 1, 1, 2'h1, 0, 3'h0, 0);
        rf(32'h4000_0000, 1, 1, 2'h2, 0, 3'h0, 0);
    endtask

    task automatic t_writes();
        ctl(1, 12'h004, d(8'h40, 8'h00, 2'h2, 0, 0, 0), 1, 0, 1, 0, 0);
        ctl(1, 12'h005, d(8'h60, 8'h00, 2'h2, 0, 1, 0), 1, 0, 1, 0, 0);
        dly = 4'h6;
        rf(32'h4000_0000, 1, 1, 0, 2'h1, 3'h0, 0);
        chk("unbuffered_wait", 9, n);
        rf(32'h6000_0000, 1, 1, 0, 2'h2, 3'h2, 0);
        chk("buffered_wait", 1, n);
        repeat (10) @(posedge clk);
        #1;
        dly = 4'h1;
        err_en = 1;
        rf(32'h4000_0000, 1, 1, 0, 2'h1, 3'h0, 0);
        err_en = 0;
        chk("prompt_wait", 4, n);
        repeat (4) @(posedge clk);
        #1;
        chk("acc_err_count", 1, acc_cnt);
    endtask

    initial begin
        repeat (10) @(posedge clk);
        #1;
        resetn = 1;
        t_regs();
        t_match();
        t_writes();
        test_done();
    end

    // Whole run is well under 400 cycles; the cut leaves a wide margin
    initial begin
        #(25 * 5000);
        error_cnt++;
        test_done();
    end
endmodule
